// ### logic/cssp_top.sv
// Clock-synchronous serial port with Avalon-MM registers and RTS/CTS handshake.
//------------------------------------------------------------------------------
// Function
// (RULE1) External clock: RTS low when ready, high on start
// (RULE2) Internal clock: RTS function has no effect
// (RULE3) Cutoff and NMI low float RTS and clock
// (RULE4) Edge select picks shift and sample edges
// (RULE5) External transmit starts only at idle clock level
// (RULE6) Empty flag 0 with data; full flag 1
// (RULE7) Transmitter makes clock; dummy data shifts out
// (RULE8) Internal clock runs after enable and buffer write
// (RULE9) External clock: shift only on partner pulses
// (RULE10) Word while full sets overrun, buffer undefined
// (RULE11) Overrun leaves receive request flag unchanged
// (RULE12) Software writes dummy byte per received word
// (RULE13) External receive needs enables and data, idle
// (RULE14) Smart-card cause and error bits raise request
// (RULE15) Eight bits per word, full after last
//------------------------------------------------------------------------------
//
// The placing of the registers and the Avalon-MM interface to the registers were left to the implementer.
`default_nettype none
module cssp_top
   import cssp_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic [cssp_pkg::CSSP_ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic i_clk_pin,
   output logic o_clk_pin,
   output logic o_clk_oe,
   input wire logic i_rx_data,
   output logic o_serial_data_out,
   output logic o_rts_n,
   output logic o_rts_oe,
   input wire logic i_cts_n,
   input wire logic i_nmi_n,
   output logic o_irq
);
   import cssp_pkg::*;

   //------------------------------------------------------------------------------
   // Synchronised pins.
   //------------------------------------------------------------------------------
   logic ext_clk;
   logic cts_n_s;
   logic nmi_n_s;
   logic rxd_s;
   cssp_pin_sync #(.RESET_VAL(1'b1)) u_sync_clk (.i_clk(i_clk), .i_reset_n(i_reset_n),
      .i_pin(i_clk_pin), .o_level(ext_clk));
   cssp_pin_sync #(.RESET_VAL(1'b1)) u_sync_cts (.i_clk(i_clk), .i_reset_n(i_reset_n),
      .i_pin(i_cts_n), .o_level(cts_n_s));
   cssp_pin_sync #(.RESET_VAL(1'b1)) u_sync_nmi (.i_clk(i_clk), .i_reset_n(i_reset_n),
      .i_pin(i_nmi_n), .o_level(nmi_n_s));
   cssp_pin_sync #(.RESET_VAL(1'b1)) u_sync_rxd (.i_clk(i_clk), .i_reset_n(i_reset_n),
      .i_pin(i_rx_data), .o_level(rxd_s));

   //------------------------------------------------------------------------------
   // Registers and bus decode.
   //------------------------------------------------------------------------------
   logic [CSSP_C0_W-1:0] ctrl0_ff;
   logic tx_en_ff;
   logic rx_en_ff;
   logic tx_empty_ff;
   logic rx_full_ff;
   logic ovr_ff;
   logic [CSSP_DATA_W-1:0] txbuf_ff;
   logic [CSSP_DATA_W-1:0] rxbuf_ff;
   logic [CSSP_IRQ_W-1:0] stat_ff;
   logic [CSSP_IRQ_W-1:0] mask_ff;
   logic [CSSP_SP_W-1:0] special_ff;
   logic ack_ff;

   wire req = i_avs_read | i_avs_write;
   wire wr_take = i_avs_write & ack_ff;
   wire rd_take = i_avs_read & ack_ff;
   wire wr_c0 = wr_take && (i_avs_address == CSSP_REG_CTRL0);
   wire wr_c1 = wr_take && (i_avs_address == CSSP_REG_CTRL1);
   wire wr_tx = wr_take && (i_avs_address == CSSP_REG_TXBUF);
   wire rd_rx = rd_take && (i_avs_address == CSSP_REG_RXBUF);
   wire wr_st = wr_take && (i_avs_address == CSSP_REG_IRQ_STAT);
   wire wr_mk = wr_take && (i_avs_address == CSSP_REG_IRQ_MASK);
   wire wr_sp = wr_take && (i_avs_address == CSSP_REG_SPECIAL);

   wire edge_sel = ctrl0_ff[CSSP_C0_EDGE];
   wire int_clk = ctrl0_ff[CSSP_C0_INTCLK];
   wire rts_sel = ctrl0_ff[CSSP_C0_RTS_SEL] & ~int_clk; // [RULE2]
   wire cts_sel = ctrl0_ff[CSSP_C0_CTS_SEL];
   wire cutoff = special_ff[CSSP_SP_CUTOFF] & ~nmi_n_s;

   //------------------------------------------------------------------------------
   // Transfer control state machine.
   //------------------------------------------------------------------------------
   typedef enum logic [2:0] {
      CSSP_IDLE = 3'b001,
      CSSP_ARM = 3'b010,
      CSSP_XFER = 3'b100
   } cssp_state_t;
   cssp_state_t state_ff;
   cssp_state_t nxt_state;

   // Idle level of the transfer clock is high for edge select 0, low for 1.
   wire idle_lvl = ~edge_sel; // [RULE5]
   wire ext_idle = (ext_clk == idle_lvl);
   wire cts_ok = ~cts_sel | ~cts_n_s;
   wire tx_ready = tx_en_ff & ~tx_empty_ff & cts_ok; // [RULE5]
   wire rx_ready = rx_en_ff & tx_en_ff & ~tx_empty_ff; // [RULE13]
   // Both directions share one shift clock, so every start, receive-only words included,
   // waits for the transmit conditions; otherwise a word could go out past a high CTS.
   wire can_start = tx_ready & (int_clk | ext_idle); // [RULE8] [RULE13]
   wire xfer_done;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         CSSP_IDLE: begin
            if (can_start) begin
               nxt_state = CSSP_ARM;
            end
         end
         CSSP_ARM: begin
            nxt_state = CSSP_XFER;
         end
         CSSP_XFER: begin
            if (xfer_done) begin
               nxt_state = CSSP_IDLE;
            end
         end
         default: begin
            nxt_state = CSSP_IDLE;
         end
      endcase
   end
   wire load = (state_ff == CSSP_IDLE) && can_start;
   wire busy = (state_ff == CSSP_XFER);

   //------------------------------------------------------------------------------
   // Internal clock generator and external edge detect.
   //------------------------------------------------------------------------------
   localparam int HCW = $clog2(CSSP_HALF_CYC + 1);
   localparam logic [HCW-1:0] HALF_LAST = HCW'(CSSP_HALF_CYC - 1);
   logic [HCW-1:0] div_ff;
   logic iclk_ff;
   logic eclk_d_ff;
   wire div_wrap = (div_ff == HALF_LAST);
   // The internal clock only toggles while a word is in flight, so it rests at idle.
   wire iclk_tgl = int_clk & busy & div_wrap; // [RULE7]
   wire xclk_prev = int_clk ? iclk_ff : eclk_d_ff;
   wire xclk_now = int_clk ? (iclk_tgl ? ~iclk_ff : iclk_ff) : ext_clk; // [RULE9]
   wire rise = ~xclk_prev & xclk_now & busy;
   wire fall = xclk_prev & ~xclk_now & busy;
   wire shift_edge = edge_sel ? rise : fall; // [RULE4]
   wire sample_edge = edge_sel ? fall : rise; // [RULE4]

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         div_ff <= '0;
         iclk_ff <= 1'b1;
         eclk_d_ff <= 1'b1;
      end else begin
         eclk_d_ff <= ext_clk;
         div_ff <= (div_wrap || !busy) ? '0 : div_ff + HCW'(1);
         if (!busy) begin
            iclk_ff <= idle_lvl;
         end else if (iclk_tgl) begin
            iclk_ff <= ~iclk_ff;
         end
      end
   end

   logic [CSSP_DATA_W-1:0] rx_word;
   logic txd;
   cssp_shifter #(.WIDTH(CSSP_DATA_W)) u_shift (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_load(load),
      .i_load_data(txbuf_ff),
      .i_shift_edge(shift_edge),
      .i_sample_edge(sample_edge),
      .i_rx_data(rxd_s),
      .o_tx_data(txd),
      .o_rx_word(rx_word),
      .o_done(xfer_done) // [RULE15]
   );

   //------------------------------------------------------------------------------
   // Control, flags and buffers.
   //------------------------------------------------------------------------------
   wire overrun = xfer_done & rx_full_ff; // [RULE10]
   wire rx_good = xfer_done & ~rx_full_ff & rx_en_ff;
   wire sim_set = wr_sp & i_avs_writedata[CSSP_SP_SIM] & i_avs_writedata[CSSP_SP_CAUSE]
      & i_avs_writedata[CSSP_SP_ERRSIG]; // [RULE14]
   wire [CSSP_IRQ_W-1:0] ev;
   assign ev[CSSP_IRQ_TX] = load | sim_set;
   assign ev[CSSP_IRQ_RX] = rx_good; // [RULE11]
   assign ev[CSSP_IRQ_OVR] = overrun;
   wire [CSSP_IRQ_W-1:0] clr = wr_st ? i_avs_writedata[CSSP_IRQ_W-1:0] : '0;

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         state_ff <= CSSP_IDLE;
         ctrl0_ff <= CSSP_C0_RST;
         tx_en_ff <= 1'b0;
         rx_en_ff <= 1'b0;
         special_ff <= '0;
         mask_ff <= '0;
         stat_ff <= '0;
         txbuf_ff <= '0;
         ack_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         ack_ff <= req & ~ack_ff;
         if (wr_c0) begin
            ctrl0_ff <= i_avs_writedata[CSSP_C0_W-1:0];
         end
         if (wr_c1) begin
            tx_en_ff <= i_avs_writedata[CSSP_C1_TXEN];
            rx_en_ff <= i_avs_writedata[CSSP_C1_RXEN];
         end
         if (wr_sp) begin
            special_ff <= i_avs_writedata[CSSP_SP_W-1:0];
         end
         if (wr_mk) begin
            mask_ff <= i_avs_writedata[CSSP_IRQ_W-1:0];
         end
         if (wr_tx) begin
            txbuf_ff <= i_avs_writedata[CSSP_DATA_W-1:0]; // [RULE12]
         end
         // A set in the same cycle as its clear wins, so no event is lost.
         stat_ff <= (stat_ff & ~clr) | ev;
      end
   end

   // The empty flag falls on a buffer write and rises once the word is loaded.
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         tx_empty_ff <= 1'b1;
         rx_full_ff <= 1'b0;
         ovr_ff <= 1'b0;
         rxbuf_ff <= '0;
      end else begin
         tx_empty_ff <= wr_tx ? 1'b0 : (load ? 1'b1 : tx_empty_ff); // [RULE6]
         rx_full_ff <= rx_good ? 1'b1 : (rd_rx ? 1'b0 : rx_full_ff); // [RULE6]
         ovr_ff <= overrun ? 1'b1 : (rd_rx ? 1'b0 : ovr_ff); // [RULE10]
         // On overrun the new word is kept, so the buffer holds the later word and the earlier one is lost.
         if (xfer_done) begin
            rxbuf_ff <= rx_word; // [RULE15]
         end
      end
   end

   //------------------------------------------------------------------------------
   // Pins, read mux and interrupt.
   //------------------------------------------------------------------------------
   logic rts_n_ff;
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         rts_n_ff <= 1'b1;
      end else begin
         rts_n_ff <= ~(rts_sel & rx_ready & (state_ff == CSSP_IDLE)); // [RULE1]
      end
   end
   assign o_rts_n = rts_n_ff;
   assign o_rts_oe = ctrl0_ff[CSSP_C0_RTS_SEL] & ~cutoff; // [RULE3]
   assign o_clk_pin = iclk_ff;
   assign o_clk_oe = int_clk & ~cutoff; // [RULE3]
   assign o_serial_data_out = txd; // [RULE7]
   assign o_irq = |(stat_ff & mask_ff);
   assign o_avs_waitrequest = req & ~ack_ff;

   wire [31:0] rd_c1 = 32'({rx_full_ff, rx_en_ff, tx_empty_ff, tx_en_ff});
   wire [31:0] rd_rxb = 32'({ovr_ff, rxbuf_ff});
   always_comb begin
      case (i_avs_address)
         CSSP_REG_CTRL0: o_avs_readdata = 32'(ctrl0_ff);
         CSSP_REG_CTRL1: o_avs_readdata = rd_c1;
         CSSP_REG_TXBUF: o_avs_readdata = 32'(txbuf_ff);
         CSSP_REG_RXBUF: o_avs_readdata = rd_rxb;
         CSSP_REG_IRQ_STAT: o_avs_readdata = 32'(stat_ff);
         CSSP_REG_IRQ_MASK: o_avs_readdata = 32'(mask_ff);
         CSSP_REG_SPECIAL: o_avs_readdata = 32'(special_ff);
         default: o_avs_readdata = 32'h0;
      endcase
   end

   //------------------------------------------------------------------------------
   // Checks.
   //------------------------------------------------------------------------------
   a_rts_int_off: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [RULE2]
      int_clk |=> o_rts_n)
      else $error("RTS asserted with internal clock");

   a_cutoff_float: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [RULE3]
      cutoff |-> !o_rts_oe && !o_clk_oe)
      else $error("pins driven in cutoff");

   a_ovr_no_rxirq: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [RULE11]
      overrun |=> stat_ff[CSSP_IRQ_RX] == $past(stat_ff[CSSP_IRQ_RX]) || $past(wr_st))
      else $error("overrun touched rx request");

   a_ovr_sets: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [RULE10]
      overrun |=> ovr_ff && stat_ff[CSSP_IRQ_OVR])
      else $error("overrun not flagged");

   a_rx_full_set: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [RULE15]
      rx_good |=> rx_full_ff)
      else $error("full flag not set");

   a_txe_write: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [RULE6]
      wr_tx |=> !tx_empty_ff)
      else $error("empty flag after write");

   a_ext_start_idle: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [RULE5]
      load && !int_clk |-> ext_clk == idle_lvl)
      else $error("start off idle level");

   a_rts_high_xfer: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [RULE1]
      busy ##1 busy |-> o_rts_n)
      else $error("RTS low during reception");

   a_rts_low_ready: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [RULE1]
      rts_sel && rx_ready && (state_ff == CSSP_IDLE) |=> !o_rts_n)
      else $error("RTS not low while ready");

   a_cts_start_gate: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [RULE5]
      load && cts_sel |-> !cts_n_s)
      else $error("start while CTS high");

   a_start_needs_data: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [RULE13]
      load |-> tx_en_ff && !tx_empty_ff)
      else $error("start without enable or data");

   a_rx_full_clr: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [RULE6]
      rd_rx && !rx_good |=> !rx_full_ff)
      else $error("full flag kept after read");

   a_clk_rest_idle: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [RULE7]
      !busy |=> o_clk_pin == $past(idle_lvl))
      else $error("clock off idle level between words");

   a_sim_tx_req: assert property (@(posedge i_clk) disable iff (!i_reset_n) // [RULE14]
      sim_set |=> stat_ff[CSSP_IRQ_TX])
      else $error("smart-card setup raised no request");
endmodule
`default_nettype wire

// ### pkg/cssp_pkg.sv
// Package with register map, field positions and constants of the clock-synchronous serial port.
`default_nettype none
package cssp_pkg;
   localparam int CSSP_ADDR_W = 4;
   localparam int CSSP_DATA_W = 8;
   // Register word offsets (byte address is four times these).
   localparam logic [3:0] CSSP_REG_CTRL0 = 4'h0;
   localparam logic [3:0] CSSP_REG_CTRL1 = 4'h1;
   localparam logic [3:0] CSSP_REG_TXBUF = 4'h2;
   localparam logic [3:0] CSSP_REG_RXBUF = 4'h3;
   localparam logic [3:0] CSSP_REG_IRQ_STAT = 4'h4;
   localparam logic [3:0] CSSP_REG_IRQ_MASK = 4'h5;
   localparam logic [3:0] CSSP_REG_SPECIAL = 4'h6;
   // serial_control_0 fields.
   localparam int CSSP_C0_EDGE = 0;
   localparam int CSSP_C0_INTCLK = 1;
   localparam int CSSP_C0_RTS_SEL = 2;
   localparam int CSSP_C0_CTS_SEL = 3;
   localparam int CSSP_C0_W = 4;
   // serial_control_1 fields.
   localparam int CSSP_C1_TXEN = 0;
   localparam int CSSP_C1_TXEMPTY = 1;
   localparam int CSSP_C1_RXEN = 2;
   localparam int CSSP_C1_RXFULL = 3;
   localparam int CSSP_C1_W = 4;
   // Interrupt status and mask fields.
   localparam int CSSP_IRQ_TX = 0;
   localparam int CSSP_IRQ_RX = 1;
   localparam int CSSP_IRQ_OVR = 2;
   localparam int CSSP_IRQ_W = 3;
   // Special control fields.
   localparam int CSSP_SP_CUTOFF = 0;
   localparam int CSSP_SP_SIM = 1;
   localparam int CSSP_SP_CAUSE = 2;
   localparam int CSSP_SP_ERRSIG = 3;
   localparam int CSSP_SP_W = 4;
   localparam int CSSP_RXBUF_OVR = 8;
   // Internal transfer clock half period.
   localparam int CSSP_CLK_NS = 10;
   localparam int CSSP_HALF_NS = 200;
   localparam int CSSP_HALF_CYC = (CSSP_HALF_NS + CSSP_CLK_NS - 1) / CSSP_CLK_NS;
   localparam logic [CSSP_C0_W-1:0] CSSP_C0_RST = 4'h0;
endpackage
`default_nettype wire

// ### logic/cssp_pin_sync.sv
// Three-stage synchroniser with a stable-level output for pins.
`default_nettype none
module cssp_pin_sync #(
   parameter logic RESET_VAL = 1'b1
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_pin,
   output logic o_level
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   logic lvl_ff;
   wire agree = (s2_ff == s3_ff);
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         s1_ff <= RESET_VAL;
         s2_ff <= RESET_VAL;
         s3_ff <= RESET_VAL;
         lvl_ff <= RESET_VAL;
      end else begin
         s1_ff <= i_pin;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         if (agree) begin
            lvl_ff <= s3_ff;
         end
      end
   end
   assign o_level = lvl_ff;
endmodule
`default_nettype wire

// ### logic/cssp_shifter.sv
// Eight-bit shift engine driven by transmit-edge and sample-edge strobes.
`default_nettype none
module cssp_shifter #(
   parameter int WIDTH = 8
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_load,
   input wire logic [WIDTH-1:0] i_load_data,
   input wire logic i_shift_edge,
   input wire logic i_sample_edge,
   input wire logic i_rx_data,
   output logic o_tx_data,
   output logic [WIDTH-1:0] o_rx_word,
   output logic o_done
);
   localparam int CW = $clog2(WIDTH + 1);
   localparam logic [CW-1:0] FULL = CW'(WIDTH);
   initial begin
      if (WIDTH < 2) $error("WIDTH must be at least 2");
   end
   logic [WIDTH-1:0] tx_ff;
   logic [WIDTH-1:0] rx_ff;
   logic [CW-1:0] cnt_ff;
   logic started_ff;
   logic txd_ff;
   logic done_ff;
   wire last = (cnt_ff == FULL - CW'(1));
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         tx_ff <= '0;
         rx_ff <= '0;
         cnt_ff <= '0;
         started_ff <= 1'b0;
         txd_ff <= 1'b1;
         done_ff <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         if (i_load) begin
            tx_ff <= i_load_data;
            cnt_ff <= '0;
            started_ff <= 1'b0;
         end else begin
            if (i_shift_edge) begin
               txd_ff <= tx_ff[0];
               tx_ff <= {1'b1, tx_ff[WIDTH-1:1]};
               started_ff <= 1'b1;
            end
            if (i_sample_edge && started_ff) begin
               rx_ff <= {i_rx_data, rx_ff[WIDTH-1:1]};
               cnt_ff <= last ? '0 : cnt_ff + CW'(1);
               done_ff <= last;
            end
         end
      end
   end
   assign o_tx_data = txd_ff;
   assign o_rx_word = rx_ff;
   assign o_done = done_ff;
endmodule
`default_nettype wire

// ### tb/cssp_partner.sv
// Behavioural far-side serial partner that shares the transfer clock.
`default_nettype none
module cssp_partner (
   input wire logic i_edge,
   input wire logic i_go,
   input wire logic i_listen,
   input wire logic i_link_clk,
   input wire logic i_dev_data,
   input wire logic [7:0] i_tx_byte,
   output logic o_clk,
   output logic o_data,
   output logic [7:0] o_rx_byte,
   output logic [7:0] o_frames
);
   timeunit 1ns;
   timeprecision 1ns;
   logic tgl = 1'b0;
   logic [2:0] nbit = 3'h0;
   logic [7:0] sr = 8'h00;
   logic dq = 1'b1;
   logic [7:0] rxq = 8'h00;
   logic [7:0] fq = 8'h00;
   //----------------------------------------
   // Clock generation
   //----------------------------------------
   // The clock rests at its idle level, so a frame always starts from it.
   assign o_clk = ~i_edge ^ tgl;
   assign o_data = dq;
   assign o_rx_byte = rxq;
   assign o_frames = fq;
   // Pulses exist only inside a frame; the clock stands still between frames.
   // The offset keeps every pin edge away from the port's sampling edge.
   initial begin
      forever begin
         wait (i_go === 1'b1);
         #2;
         repeat (16) begin
            #40;
            tgl = ~tgl;
         end
         wait (i_go === 1'b0);
      end
   end
   //----------------------------------------
   // Data shifting
   //----------------------------------------
   // Sampling waits a little because the port sees the clock through a synchroniser.
   always @(i_link_clk) begin
      if (i_listen !== 1'b1) begin
         nbit = 3'h0;
      end else if (i_link_clk === i_edge) begin
         dq = i_tx_byte[nbit];
      end else begin
         #30;
         sr[nbit] = i_dev_data;
         if (nbit == 3'h7) begin
            rxq = sr;
            fq = fq + 8'h01;
            // The line is inverted, so it no longer shows the last bit.
            dq = ~dq;
         end
         nbit = nbit + 3'h1;
      end
   end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking testbench for the clock-synchronous serial port.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import cssp_pkg::*;
   logic i_clk = 1'b0;
   logic i_reset_n = 1'b0;
   logic [3:0] adr = 4'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata, v;
   logic waitreq, dclk, dclk_oe, ddata, rts_n, rts_oe, irq;
   logic cts_n = 1'b1;
   logic nmi_n = 1'b1;
   logic ext = 1'b0;
   logic esel = 1'b0;
   logic go = 1'b0;
   logic listen = 1'b0;
   logic [7:0] ptx = 8'h00;
   logic [7:0] prx, frames;
   logic pclk, pdata, clk_wire;
   int mismatches = 0;
   int checks_done = 0;
   int nedges = 0;
   // The clock pin has a pull-up when nobody drives it.
   assign clk_wire = dclk_oe ? dclk : (ext ? pclk : 1'b1);
   initial begin
      forever #5 i_clk = ~i_clk;
   end
   always @(dclk) begin
      if (listen) nedges++;
   end
   cssp_top i_cssp_top (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_avs_address(adr),
      .i_avs_read(rd),
      .i_avs_write(wr),
      .i_avs_writedata(wdata),
      .o_avs_readdata(rdata),
      .o_avs_waitrequest(waitreq),
      .i_clk_pin(clk_wire),
      .o_clk_pin(dclk),
      .o_clk_oe(dclk_oe),
      .i_rx_data(pdata),
      .o_serial_data_out(ddata),
      .o_rts_n(rts_n),
      .o_rts_oe(rts_oe),
      .i_cts_n(cts_n),
      .i_nmi_n(nmi_n),
      .o_irq(irq)
   );
   cssp_partner i_cssp_partner (
      .i_edge(esel),
      .i_go(go),
      .i_listen(listen),
      .i_link_clk(clk_wire),
      .i_dev_data(ddata),
      .i_tx_byte(ptx),
      .o_clk(pclk),
      .o_data(pdata),
      .o_rx_byte(prx),
      .o_frames(frames)
   );
   //----------------------------------------
   // Tasks
   //----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One bus access; the request is held until waitrequest is seen low at an edge.
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      adr <= a;
      wdata <= d;
      wr <= w;
      rd <= ~w;
      do begin
         @(posedge i_clk);
      end while (waitreq !== 1'b0);
      v = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge i_clk);
   endtask
   task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(v, e);
   endtask
   task automatic ticks(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   // Ten extra cycles cover the input synchronisers of the port.
   task automatic wait_frame();
      logic [7:0] f0;
      f0 = frames;
      // A frame that never ends is left to the watchdog.
      while (frames === f0) begin
         @(posedge i_clk);
      end
      ticks(10);
   endtask
   task automatic done_test(input string s);
      $display("test %s finished", s);
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge i_clk);
      mismatches++;
      final_report();
   end
   //----------------------------------------
   // Tests
   //----------------------------------------
   initial begin
      repeat (20) @(posedge i_clk);
      i_reset_n <= 1'b1;
      @(posedge i_clk);
      rdchk(CSSP_REG_CTRL0, 32'h0);
      rdchk(CSSP_REG_CTRL1, 32'h2);
      rdchk(CSSP_REG_IRQ_STAT, 32'h0);
      bus(1'b1, 4'hf, 32'hff);
      rdchk(4'hf, 32'h0);
      chk({31'h0, irq}, 32'h0);
      done_test("reset");
      bus(1'b1, CSSP_REG_IRQ_MASK, 32'h7);
      bus(1'b1, CSSP_REG_CTRL0, 32'h6);
      bus(1'b1, CSSP_REG_CTRL1, 32'h4);
      ptx <= 8'h3c;
      listen <= 1'b1;
      bus(1'b1, CSSP_REG_TXBUF, 32'ha5);
      rdchk(CSSP_REG_CTRL1, 32'h4);
      ticks(50);
      chk(nedges, 0);
      bus(1'b1, CSSP_REG_CTRL1, 32'h5);
      wait_frame();
      chk(nedges, 16);
      chk({24'h0, prx}, 32'ha5);
      rdchk(CSSP_REG_IRQ_STAT, 32'h3);
      chk({31'h0, irq}, 32'h1);
      rdchk(CSSP_REG_CTRL1, 32'hf);
      rdchk(CSSP_REG_RXBUF, 32'h3c);
      rdchk(CSSP_REG_CTRL1, 32'h7);
      bus(1'b1, CSSP_REG_IRQ_STAT, 32'h7);
      chk({31'h0, irq}, 32'h0);
      done_test("internal");
      bus(1'b1, CSSP_REG_IRQ_MASK, 32'h2);
      ptx <= 8'h81;
      bus(1'b1, CSSP_REG_TXBUF, 32'h55);
      wait_frame();
      bus(1'b1, CSSP_REG_IRQ_STAT, 32'h7);
      ptx <= 8'h18;
      bus(1'b1, CSSP_REG_TXBUF, 32'h55);
      wait_frame();
      rdchk(CSSP_REG_IRQ_STAT, 32'h5);
      chk({31'h0, irq}, 32'h0);
      bus(1'b0, CSSP_REG_RXBUF, 32'h0);
      chk(v & 32'h100, 32'h100);
      rdchk(CSSP_REG_CTRL1, 32'h7);
      listen <= 1'b0;
      done_test("overrun");
      ext <= 1'b1;
      esel <= 1'b1;
      bus(1'b1, CSSP_REG_CTRL0, 32'hd);
      ptx <= 8'hc3;
      bus(1'b1, CSSP_REG_TXBUF, 32'h5a);
      ticks(20);
      rdchk(CSSP_REG_CTRL1, 32'h5);
      chk({30'h0, rts_n, rts_oe}, 32'h1);
      chk({31'h0, dclk_oe}, 32'h0);
      cts_n <= 1'b0;
      listen <= 1'b1;
      ticks(10);
      go <= 1'b1;
      ticks(30);
      chk({31'h0, rts_n}, 32'h1);
      wait_frame();
      go <= 1'b0;
      chk({24'h0, prx}, 32'h5a);
      rdchk(CSSP_REG_RXBUF, 32'hc3);
      listen <= 1'b0;
      done_test("external");
      ext <= 1'b0;
      bus(1'b1, CSSP_REG_CTRL0, 32'h6);
      bus(1'b1, CSSP_REG_SPECIAL, 32'h1);
      chk({30'h0, dclk_oe, rts_oe}, 32'h3);
      nmi_n <= 1'b0;
      ticks(10);
      chk({30'h0, dclk_oe, rts_oe}, 32'h0);
      nmi_n <= 1'b1;
      ticks(10);
      chk({30'h0, dclk_oe, rts_oe}, 32'h3);
      done_test("cutoff");
      bus(1'b1, CSSP_REG_IRQ_STAT, 32'h7);
      bus(1'b1, CSSP_REG_IRQ_MASK, 32'h1);
      bus(1'b1, CSSP_REG_SPECIAL, 32'he);
      rdchk(CSSP_REG_IRQ_STAT, 32'h1);
      chk({31'h0, irq}, 32'h1);
      bus(1'b1, CSSP_REG_IRQ_STAT, 32'h1);
      rdchk(CSSP_REG_IRQ_STAT, 32'h0);
      chk({31'h0, irq}, 32'h0);
      done_test("smart_card");
      final_report();
   end
endmodule
`default_nettype wire
